// [rtl/eas_sequencer.sv]
// Exception acknowledge sequencer: interrupts, traps, trace, service step.
// Assumes the pipeline signals boundaries and holds status until done.
`default_nettype none
module eas_sequencer (
	// Clocking
	input wire logic clock,
	input wire logic srst,
	input wire logic clkEn,
	// Request pins
	input wire logic nmiReqN,
	input wire logic intReqN,
	// Configuration
	input wire logic vectoredMode,
	input wire logic directException,
	// Pipeline state
	input wire logic [15:0] processorStatusWord,
	input wire logic [15:0] statusAtInstrStart,
	input wire logic [31:0] vectorTableBase,
	input wire logic [15:0] descriptorBaseRegister,
	input wire logic [23:0] instrAddr,
	input wire logic [23:0] nextInstrAddr,
	// Pipeline events
	input wire logic instrBoundary,
	input wire logic interruptPoint,
	input wire logic stringUnfinished,
	input wire logic instrEnd,
	input wire logic [6:0] trapReq,
	input wire logic traceSuppress,
	input wire logic waitInstr,
	input wire logic returnDone,
	// Pipeline answers
	output logic [15:0] statusOut,
	output logic statusLoad,
	output logic stackRestore,
	output logic instrComplete,
	output logic [31:0] programCounter,
	output logic pcLoad,
	output logic [31:0] staticBase,
	output logic [15:0] newModule,
	output logic moduleLoad,
	output logic queueFlush,
	output logic busy,
	// System bus
	output logic busReq,
	output logic [23:0] busAddr,
	output logic [3:0] busStatus,
	output logic [1:0] busSize,
	output logic busWrite,
	output logic [31:0] busWdata,
	input wire logic busDone,
	input wire logic [31:0] busRdata
);
	eas_pkg::eas_state_type state_r;
	logic nmiFall;
	logic intActive;
	logic nmiPend_r;
	logic [15:0] psrCopy_r;
	logic [7:0] vector_r;
	logic [23:0] retAddr_r;
	logic [31:0] entry_r;
	logic direct_r;
	logic isNmi_r;
	logic traceDefer_r;
	logic traceTrapPend_r;
	logic [7:0] trapVec;
	logic [15:0] intCopy;
	logic [15:0] intClr;
	logic [15:0] trapCopy;
	logic [15:0] trapClr;
	logic [15:0] trcCopy;
	logic [15:0] trcClr;
	logic nmiAny;
	logic intSync;
	eas_nmi_edge nmiEdge (
		.clock(clock),
		.srst(srst),
		.clkEn(clkEn),
		.nmiReqN(nmiReqN),
		.nmiFall(nmiFall)
	);
	eas_sync intSyncInst (
		.clock(clock),
		.srst(srst),
		.clkEn(clkEn),
		.din(~intReqN),
		.dout(intSync)
	);
	assign intActive = intSync & processorStatusWord[eas_pkg::PSR_I];
	always_comb begin
		trapVec = eas_pkg::VEC_SLAVE;
		if (trapReq[eas_pkg::TR_PRIV]) trapVec = eas_pkg::VEC_PRIV;
		if (trapReq[eas_pkg::TR_SVC]) trapVec = eas_pkg::VEC_SVC;
		if (trapReq[eas_pkg::TR_DVZ]) trapVec = eas_pkg::VEC_DVZ;
		if (trapReq[eas_pkg::TR_FLAG]) trapVec = eas_pkg::VEC_FLAG;
		if (trapReq[eas_pkg::TR_BPT]) trapVec = eas_pkg::VEC_BPT;
		if (trapReq[eas_pkg::TR_UND]) trapVec = eas_pkg::VEC_UND;
	end
	// Edge counts at once, so NMI is never behind the equally fast two-flop level path
	assign nmiAny = nmiPend_r | nmiFall;
	always_ff @(posedge clock) begin
		if (srst) begin
			nmiPend_r <= 1'b0;
		end else if (clkEn) begin
			if (state_r == eas_pkg::ST_IDLE && nmiAny && (instrBoundary || interruptPoint)) begin
				nmiPend_r <= 1'b0;
			end else if (nmiFall) begin
				nmiPend_r <= 1'b1;
			end
		end
	end
	always_comb begin
		intCopy = processorStatusWord;
		if (interruptPoint && stringUnfinished) begin
			intCopy[eas_pkg::PSR_P] = 1'b0;
		end
		intClr = intCopy;
		intClr[eas_pkg::PSR_S] = 1'b0;
		intClr[eas_pkg::PSR_U] = 1'b0;
		intClr[eas_pkg::PSR_T] = 1'b0;
		intClr[eas_pkg::PSR_P] = 1'b0;
		intClr[eas_pkg::PSR_I] = 1'b0;
		trapCopy = statusAtInstrStart;
		if (trapReq[eas_pkg::TR_UND]) begin
			trapCopy[eas_pkg::PSR_P] = 1'b0;
		end
		trapClr = trapCopy;
		trapClr[eas_pkg::PSR_T] = 1'b0;
		trapClr[eas_pkg::PSR_U] = 1'b0;
		trapClr[eas_pkg::PSR_S] = 1'b0;
		trapClr[eas_pkg::PSR_P] = 1'b0;
		trcCopy = processorStatusWord;
		trcCopy[eas_pkg::PSR_P] = 1'b0;
		trcClr = trcCopy;
		trcClr[eas_pkg::PSR_S] = 1'b0;
		trcClr[eas_pkg::PSR_U] = 1'b0;
		trcClr[eas_pkg::PSR_T] = 1'b0;
	end
	// Main sequencing
	always_ff @(posedge clock) begin
		if (srst) begin
			state_r <= eas_pkg::ST_IDLE;
			psrCopy_r <= 16'h0000;
			vector_r <= 8'h00;
			retAddr_r <= 24'h000000;
			entry_r <= 32'h00000000;
			direct_r <= 1'b0;
			isNmi_r <= 1'b0;
			traceDefer_r <= 1'b0;
			traceTrapPend_r <= 1'b0;
			statusOut <= 16'h0000;
			statusLoad <= 1'b0;
			stackRestore <= 1'b0;
			instrComplete <= 1'b0;
			programCounter <= 32'h00000000;
			pcLoad <= 1'b0;
			staticBase <= 32'h00000000;
			newModule <= 16'h0000;
			moduleLoad <= 1'b0;
			queueFlush <= 1'b0;
			busy <= 1'b0;
			busReq <= 1'b0;
			busAddr <= 24'h000000;
			busStatus <= 4'h0;
			busSize <= 2'h0;
			busWrite <= 1'b0;
			busWdata <= 32'h00000000;
		end else if (clkEn) begin
			statusLoad <= 1'b0;
			stackRestore <= 1'b0;
			instrComplete <= 1'b0;
			pcLoad <= 1'b0;
			moduleLoad <= 1'b0;
			queueFlush <= 1'b0;
			if (traceDefer_r && returnDone) begin
				traceDefer_r <= 1'b0;
				traceTrapPend_r <= 1'b1;
			end
			unique case (state_r)
				eas_pkg::ST_IDLE: begin
					busy <= 1'b0;
					if ((nmiAny || intActive) && (instrBoundary || interruptPoint)) begin
						if (interruptPoint && stringUnfinished) begin
							retAddr_r <= instrAddr;
						end else begin
							retAddr_r <= nextInstrAddr;
						end
						// Pending cleared in the copy for unfinished string instructions
						psrCopy_r <= intCopy;
						statusOut <= intClr;
						statusLoad <= 1'b1;
						// Trace after this service if pending, unless a string instruction is unfinished
						if (processorStatusWord[eas_pkg::PSR_P] && !(interruptPoint && stringUnfinished)) begin
							traceTrapPend_r <= 1'b1;
						end
						isNmi_r <= nmiAny;
						busAddr <= nmiAny ? eas_pkg::ACK_ADDR_NMI : eas_pkg::ACK_ADDR_INT;
						busStatus <= eas_pkg::STS_ACK_MASTER;
						busSize <= eas_pkg::SZ_BYTE;
						busWrite <= 1'b0;
						busReq <= 1'b1;
						busy <= 1'b1;
						state_r <= eas_pkg::ST_ACK;
					end else if (instrEnd && |trapReq) begin
						stackRestore <= 1'b1;
						// Bad opcode copy has pending cleared
						psrCopy_r <= trapCopy;
						statusOut <= trapClr;
						statusLoad <= 1'b1;
						// No trace pending copy on bad opcode
						if (!trapReq[eas_pkg::TR_UND] && statusAtInstrStart[eas_pkg::PSR_P]) begin
							traceTrapPend_r <= 1'b1;
						end
						vector_r <= trapVec;
						retAddr_r <= instrAddr;
						busy <= 1'b1;
						state_r <= eas_pkg::ST_PUSH_PSR;
					end else if (instrEnd && waitInstr && processorStatusWord[eas_pkg::PSR_P]) begin
						traceDefer_r <= 1'b1;
						instrComplete <= 1'b1;
					end else if ((instrEnd && processorStatusWord[eas_pkg::PSR_P] && !traceSuppress)
						|| (traceTrapPend_r && instrBoundary)) begin
						// Pending at end raises trace trap
						traceTrapPend_r <= 1'b0;
						psrCopy_r <= trcCopy;
						statusOut <= trcClr;
						statusLoad <= 1'b1;
						instrComplete <= instrEnd;
						vector_r <= eas_pkg::VEC_TRACE;
						retAddr_r <= nextInstrAddr;
						busy <= 1'b1;
						state_r <= eas_pkg::ST_PUSH_PSR;
					end else if (instrEnd) begin
						instrComplete <= 1'b1;
					end
				end
				eas_pkg::ST_ACK: begin
					if (busDone) begin
						busReq <= 1'b0;
						if (isNmi_r) begin
							vector_r <= eas_pkg::VEC_NMI;
							state_r <= eas_pkg::ST_PUSH_PSR;
						end else if (!vectoredMode) begin
							vector_r <= eas_pkg::VEC_NVI;
							state_r <= eas_pkg::ST_PUSH_PSR;
						end else if (!busRdata[7]) begin
							vector_r <= busRdata[7:0];
							state_r <= eas_pkg::ST_PUSH_PSR;
						end else if (busRdata[7:0] >= eas_pkg::CASCADE_MIN) begin
							busAddr <= 24'(vectorTableBase + {{22{1'b1}}, busRdata[7:0], 2'b00});
							busStatus <= eas_pkg::STS_MEM_READ;
							busSize <= eas_pkg::SZ_DWORD;
							busReq <= 1'b1;
							state_r <= eas_pkg::ST_CASC_ADDR;
						end else begin
							vector_r <= busRdata[7:0];
							state_r <= eas_pkg::ST_PUSH_PSR;
						end
					end
				end
				eas_pkg::ST_CASC_ADDR: begin
					if (busDone) begin
						busAddr <= busRdata[23:0];
						busStatus <= eas_pkg::STS_ACK_CASCADE;
						busSize <= eas_pkg::SZ_BYTE;
						state_r <= eas_pkg::ST_CASC_VEC;
					end
				end
				eas_pkg::ST_CASC_VEC: begin
					if (busDone) begin
						busReq <= 1'b0;
						vector_r <= busRdata[7:0];
						state_r <= eas_pkg::ST_PUSH_PSR;
					end
				end
				eas_pkg::ST_PUSH_PSR: begin
					direct_r <= directException;
					busAddr <= 24'h000000;
					busStatus <= eas_pkg::STS_MEM_WRITE;
					busSize <= eas_pkg::SZ_WORD;
					busWrite <= 1'b1;
					busWdata <= {16'h0000, psrCopy_r};
					busReq <= 1'b1;
					state_r <= eas_pkg::ST_READ_IDT;
				end
				eas_pkg::ST_READ_IDT: begin
					if (busDone) begin
						busAddr <= 24'(vectorTableBase + {22'h000000, vector_r, 2'b00});
						busStatus <= eas_pkg::STS_MEM_READ;
						busSize <= eas_pkg::SZ_DWORD;
						busWrite <= 1'b0;
						state_r <= eas_pkg::ST_READ_PB;
					end
				end
				eas_pkg::ST_READ_PB: begin
					if (busDone) begin
						entry_r <= busRdata;
						if (direct_r) begin
							programCounter <= busRdata;
							pcLoad <= 1'b1;
							busAddr <= 24'h000000;
							busStatus <= eas_pkg::STS_MEM_WRITE;
							busWrite <= 1'b1;
							busWdata <= {8'h00, retAddr_r};
							state_r <= eas_pkg::ST_FETCH;
						end else begin
							// Program base at module plus offset
							busAddr <= {8'h00, busRdata[15:0]} + eas_pkg::PROG_BASE_OFS;
							state_r <= eas_pkg::ST_READ_SB;
						end
					end
				end
				eas_pkg::ST_READ_SB: begin
					if (busDone) begin
						programCounter <= busRdata + {16'h0000, entry_r[31:16]};
						pcLoad <= 1'b1;
						busAddr <= {8'h00, entry_r[15:0]};
						state_r <= eas_pkg::ST_PUSH_MOD;
					end
				end
				eas_pkg::ST_PUSH_MOD: begin
					if (busDone) begin
						staticBase <= busRdata;
						busStatus <= eas_pkg::STS_MEM_WRITE;
						busSize <= eas_pkg::SZ_WORD;
						busWrite <= 1'b1;
						busWdata <= {16'h0000, descriptorBaseRegister};
						busAddr <= 24'h000000;
						newModule <= entry_r[15:0];
						moduleLoad <= 1'b1;
						state_r <= eas_pkg::ST_PUSH_RET;
					end
				end
				eas_pkg::ST_PUSH_RET: begin
					if (busDone) begin
						// Push return address as 32 bits
						busSize <= eas_pkg::SZ_DWORD;
						busWdata <= {8'h00, retAddr_r};
						state_r <= eas_pkg::ST_FETCH;
					end
				end
				eas_pkg::ST_FETCH: begin
					if (busDone) begin
						busReq <= 1'b0;
						busWrite <= 1'b0;
						queueFlush <= 1'b1;
						state_r <= eas_pkg::ST_DONE;
					end
				end
				eas_pkg::ST_DONE: begin
					busy <= 1'b0;
					state_r <= eas_pkg::ST_IDLE;
				end
				default: begin
					state_r <= eas_pkg::ST_IDLE;
				end
			endcase
		end
	end
	a_ack_status: assert property (@(posedge clock) disable iff (srst)
		(state_r == eas_pkg::ST_ACK) |-> (busStatus == eas_pkg::STS_ACK_MASTER))
		else $error("acknowledge status wrong");
	a_casc_status: assert property (@(posedge clock) disable iff (srst)
		(state_r == eas_pkg::ST_CASC_VEC) |-> (busStatus == eas_pkg::STS_ACK_CASCADE))
		else $error("cascade status wrong");
	a_flush_seq: assert property (@(posedge clock) disable iff (srst)
		queueFlush |-> $past(state_r) == eas_pkg::ST_FETCH)
		else $error("flush out of sequence");
	a_nmi_vector: assert property (@(posedge clock) disable iff (srst)
		(state_r == eas_pkg::ST_ACK && busDone && isNmi_r) |=> (vector_r == eas_pkg::VEC_NMI))
		else $error("NMI vector wrong");
	a_trap_ie_kept: assert property (@(posedge clock) disable iff (srst)
		stackRestore |-> (statusOut[eas_pkg::PSR_I] == $past(statusAtInstrStart[eas_pkg::PSR_I])))
		else $error("trap changed interrupt enable");
	a_int_clears: assert property (@(posedge clock) disable iff (srst)
		($rose(busy) && busReq && busStatus == eas_pkg::STS_ACK_MASTER) |-> !statusOut[eas_pkg::PSR_I])
		else $error("interrupt enable not cleared");
	// Service ends one cycle after flush
	sequence s_service_end;
		(state_r == eas_pkg::ST_DONE) ##1 !busy;
	endsequence
	a_flush_release: assert property (@(posedge clock) disable iff (srst)
		queueFlush |-> s_service_end)
		else $error("busy held after flush");
endmodule // eas_sequencer
`default_nettype wire

// [inc/eas_pkg.sv]
// Constants for the exception acknowledge sequencer.
// Assumes a 24-bit system bus and 16-bit status word.
`default_nettype none
package eas_pkg;
	localparam logic [23:0] ACK_ADDR_NMI = 24'hffff00;
	localparam logic [23:0] ACK_ADDR_INT = 24'hfffe00;
	localparam logic [3:0] STS_ACK_MASTER = 4'h4;
	localparam logic [3:0] STS_ACK_CASCADE = 4'h5;
	localparam logic [3:0] STS_MEM_READ = 4'h8;
	localparam logic [3:0] STS_MEM_WRITE = 4'ha;
	localparam logic [7:0] VEC_NVI = 8'h00;
	localparam logic [7:0] VEC_NMI = 8'h01;
	localparam logic [7:0] VEC_SLAVE = 8'h03;
	localparam logic [7:0] VEC_PRIV = 8'h04;
	localparam logic [7:0] VEC_SVC = 8'h05;
	localparam logic [7:0] VEC_DVZ = 8'h06;
	localparam logic [7:0] VEC_FLAG = 8'h07;
	localparam logic [7:0] VEC_BPT = 8'h08;
	localparam logic [7:0] VEC_TRACE = 8'h09;
	localparam logic [7:0] VEC_UND = 8'h0a;
	localparam logic [7:0] CASCADE_MIN = 8'hf0;
	localparam logic [23:0] PROG_BASE_OFS = 24'h000008;
	// Status word bit positions
	localparam int PSR_T = 1;
	localparam int PSR_P = 10;
	localparam int PSR_S = 9;
	localparam int PSR_U = 8;
	localparam int PSR_I = 11;
	// Bus sizes
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_WORD = 2'h1;
	localparam logic [1:0] SZ_DWORD = 2'h3;
	// Trap one-hot indices
	localparam int TR_SLAVE = 0;
	localparam int TR_PRIV = 1;
	localparam int TR_SVC = 2;
	localparam int TR_DVZ = 3;
	localparam int TR_FLAG = 4;
	localparam int TR_BPT = 5;
	localparam int TR_UND = 6;
	localparam int TRAP_COUNT = 7;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ACK = 4'h1,
		ST_CASC_ADDR = 4'h2,
		ST_CASC_VEC = 4'h3,
		ST_PUSH_PSR = 4'h4,
		ST_READ_IDT = 4'h5,
		ST_READ_PB = 4'h6,
		ST_READ_SB = 4'h7,
		ST_PUSH_MOD = 4'h8,
		ST_PUSH_RET = 4'h9,
		ST_FETCH = 4'ha,
		ST_DONE = 4'hb
	} eas_state_type;
endpackage
`default_nettype wire

// [rtl/eas_nmi_edge.sv]
// Falling-edge detector for the non-maskable request pin.
// Assumes an asynchronous pin; two synchroniser stages precede the edge logic.
`default_nettype none
module eas_nmi_edge (
	// Clocking
	input wire logic clock,
	input wire logic srst,
	input wire logic clkEn,
	// Pin and event
	input wire logic nmiReqN,
	output logic nmiFall
);
	logic sync1_r;
	logic sync2_r;
	logic prev_r;
	always_ff @(posedge clock) begin
		if (srst) begin
			sync1_r <= 1'b1;
			sync2_r <= 1'b1;
			prev_r <= 1'b1;
		end else if (clkEn) begin
			sync1_r <= nmiReqN;
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
		end
	end
	assign nmiFall = clkEn & prev_r & ~sync2_r;
endmodule // eas_nmi_edge
`default_nettype wire

// [rtl/eas_sync.sv]
// Two-flop level synchroniser.
// Assumes the input may change at any time relative to clock.
`default_nettype none
module eas_sync (
	// Clocking
	input wire logic clock,
	input wire logic srst,
	input wire logic clkEn,
	// Level
	input wire logic din,
	output logic dout
);
	logic stage1_r;
	logic stage2_r;
	always_ff @(posedge clock) begin
		if (srst) begin
			stage1_r <= 1'b0;
			stage2_r <= 1'b0;
		end else if (clkEn) begin
			stage1_r <= din;
			stage2_r <= stage1_r;
		end
	end
	assign dout = stage2_r;
endmodule // eas_sync
`default_nettype wire

// [tb/eas_bus_model.sv]
// Bus partner of the sequencer: interrupt controllers and stack/table memory.
// Assumes the sequencer holds busReq and its qualifiers until busDone is seen.
`default_nettype none
module eas_bus_model (
	// Clocking
	input wire logic clock,
	input wire logic srst,
	// Setup
	input wire logic [3:0] lag,
	input wire logic [7:0] ackByte,
	input wire logic [7:0] casVec,
	// Bus
	input wire logic busReq,
	input wire logic [23:0] busAddr,
	input wire logic [3:0] busStatus,
	input wire logic [1:0] busSize,
	input wire logic busWrite,
	input wire logic [31:0] busWdata,
	output logic busDone,
	output logic [31:0] busRdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] waitCnt;
	logic [23:0] logAddr [0:63];
	logic [3:0] logSts [0:63];
	logic [1:0] logSize [0:63];
	logic logWr [0:63];
	logic [31:0] logData [0:63];
	int n;
	always_ff @(posedge clock) begin
		if (srst) begin
			busDone <= 1'b0;
			busRdata <= 32'h0;
			waitCnt <= 4'h0;
			n <= 0;
		end else if (busReq && !busDone && waitCnt >= lag) begin
			busDone <= 1'b1;
			waitCnt <= 4'h0;
			logAddr[n] <= busAddr;
			logSts[n] <= busStatus;
			logSize[n] <= busSize;
			logWr[n] <= busWrite;
			logData[n] <= busWdata;
			n <= n + 1;
			if (busStatus == 4'h4)
				busRdata <= {24'ha5a5a5, ackByte};
			else if (busStatus == 4'h5)
				busRdata <= {24'h3c3c3c, casVec};
			else
				busRdata <= {8'h5a, busAddr};
		end else begin
			busDone <= 1'b0;
			// Released data never keeps its last value
			busRdata <= ~busRdata;
			if (busReq && !busDone)
				waitCnt <= waitCnt + 4'h1;
		end
	end
endmodule // eas_bus_model
`default_nettype wire

// [tb/exception_acknowledge_sequencer_tb_top.sv]
// Testbench: drives pipeline events and pins, checks bus traffic and loads.
// Assumes eas_bus_model answers every bus request of the sequencer.
`default_nettype none
module exception_acknowledge_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, srst, clkEn, nmiReqN, intReqN, vectoredMode, directException;
	logic [15:0] processorStatusWord, statusAtInstrStart, descriptorBaseRegister, statusOut, newModule;
	logic [31:0] vectorTableBase, programCounter, staticBase, busWdata, busRdata;
	logic [23:0] instrAddr, nextInstrAddr, busAddr;
	logic instrBoundary, interruptPoint, stringUnfinished, instrEnd, traceSuppress, waitInstr, returnDone;
	logic [6:0] trapReq;
	logic statusLoad, stackRestore, instrComplete, pcLoad, moduleLoad, queueFlush, busy;
	logic busReq, busWrite, busDone;
	logic [3:0] busStatus, lag;
	logic [1:0] busSize;
	logic [7:0] ackByte, casVec;
	logic [31:0] pcSeen;
	logic [15:0] stSeen, modSeen;
	int badCount = 0;
	int comparisons = 0;
	int flushCnt = 0;
	int restoreCnt = 0;
	int s0, f0;
	localparam logic [7:0] trapVec [0:6] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0a};

	eas_sequencer u_dut (.clock, .srst, .clkEn, .nmiReqN, .intReqN, .vectoredMode, .directException,
		.processorStatusWord, .statusAtInstrStart, .vectorTableBase, .descriptorBaseRegister, .instrAddr,
		.nextInstrAddr, .instrBoundary, .interruptPoint, .stringUnfinished, .instrEnd, .trapReq, .traceSuppress,
		.waitInstr, .returnDone, .statusOut, .statusLoad, .stackRestore, .instrComplete, .programCounter, .pcLoad,
		.staticBase, .newModule, .moduleLoad, .queueFlush, .busy, .busReq, .busAddr, .busStatus, .busSize,
		.busWrite, .busWdata, .busDone, .busRdata);
	eas_bus_model u_mem (.clock, .srst, .lag, .ackByte, .casVec, .busReq, .busAddr, .busStatus, .busSize,
		.busWrite, .busWdata, .busDone, .busRdata);

	always #4 clock = ~clock;

	always @(posedge clock) begin
		if (pcLoad === 1'b1) pcSeen <= programCounter;
		if (statusLoad === 1'b1) stSeen <= statusOut;
		if (moduleLoad === 1'b1) modSeen <= newModule;
		if (queueFlush === 1'b1) flushCnt <= flushCnt + 1;
		if (stackRestore === 1'b1) restoreCnt <= restoreCnt + 1;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			badCount++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Pushes are judged by data, reads by address
	task automatic xfer(input int i, input logic [23:0] a, input logic [3:0] s, input logic [1:0] z,
		input logic w, input logic [31:0] d);
		int k;
		k = s0 + i;
		check("bus status", {28'h0, u_mem.logSts[k]}, {28'h0, s});
		check("bus size", {30'h0, u_mem.logSize[k]}, {30'h0, z});
		check("bus write", {31'h0, u_mem.logWr[k]}, {31'h0, w});
		if (w)
			check("push data", (z == 2'h1) ? {16'h0, u_mem.logData[k][15:0]} : u_mem.logData[k], d);
		else
			check("bus address", {8'h0, u_mem.logAddr[k]}, {8'h0, a});
	endtask

	// Waits for one whole service, releasing the requests once it starts
	task automatic serve(input int cnt);
		int k;
		k = 0;
		s0 = u_mem.n;
		f0 = flushCnt;
		while (busy !== 1'b1 && k < 40) begin
			@(posedge clock);
			k++;
		end
		nmiReqN <= 1'b1;
		intReqN <= 1'b1;
		instrBoundary <= 1'b0;
		interruptPoint <= 1'b0;
		trapReq <= 7'h0;
		instrEnd <= 1'b0;
		while (busy !== 1'b0 && k < 400) begin
			@(posedge clock);
			k++;
		end
		repeat (2) @(posedge clock);
		check("transfer count", u_mem.n - s0, cnt);
		check("queue flushes", flushCnt - f0, 1);
		stringUnfinished <= 1'b0;
		repeat (4) @(posedge clock);
	endtask

	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", comparisons, badCount);
		if (badCount == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		#(60000 * 8);
		badCount++;
		close_out();
	end

	initial begin
		clock = 0; srst = 1; clkEn = 1; nmiReqN = 1; intReqN = 1; vectoredMode = 0; directException = 1;
		processorStatusWord = 16'h0f22; statusAtInstrStart = 16'h0f26; vectorTableBase = 32'h00001000;
		descriptorBaseRegister = 16'h0777; instrAddr = 24'h000400; nextInstrAddr = 24'h000406;
		instrBoundary = 0; interruptPoint = 0; stringUnfinished = 0; instrEnd = 0; trapReq = 7'h0;
		traceSuppress = 0; waitInstr = 0; returnDone = 0; lag = 0; ackByte = 0; casVec = 0;
		repeat (6) @(posedge clock);
		srst <= 1'b0;
		repeat (4) @(posedge clock);
		// Maskable request with interrupts disabled
		processorStatusWord <= 16'h0722;
		intReqN <= 1'b0;
		instrBoundary <= 1'b1;
		repeat (12) @(posedge clock);
		check("busy while disabled", {31'h0, busy}, 32'h0);
		intReqN <= 1'b1;
		instrBoundary <= 1'b0;
		repeat (4) @(posedge clock);
		processorStatusWord <= 16'h0f22;
		// Both requests at once, direct mode
		nmiReqN <= 1'b0;
		intReqN <= 1'b0;
		instrBoundary <= 1'b1;
		serve(4);
		xfer(0, 24'hffff00, 4'h4, 2'h0, 1'b0, 0);
		xfer(1, 0, 4'ha, 2'h1, 1'b1, 32'h0f22);
		xfer(2, 24'h001004, 4'h8, 2'h3, 1'b0, 0);
		xfer(3, 0, 4'ha, 2'h3, 1'b1, 32'h406);
		check("pc direct", pcSeen, 32'h5a001004);
		check("status cleared", {16'h0, stSeen}, 32'h0020);
		// Non-vectored, slow bus
		lag <= 4'h2;
		intReqN <= 1'b0;
		repeat (3) @(posedge clock);
		instrBoundary <= 1'b1;
		serve(4);
		xfer(0, 24'hfffe00, 4'h4, 2'h0, 1'b0, 0);
		xfer(2, 24'h001000, 4'h8, 2'h3, 1'b0, 0);
		// Vectored, descriptor mode, unfinished string
		lag <= 4'h0;
		vectoredMode <= 1'b1;
		directException <= 1'b0;
		ackByte <= 8'h25;
		stringUnfinished <= 1'b1;
		intReqN <= 1'b0;
		repeat (3) @(posedge clock);
		interruptPoint <= 1'b1;
		serve(7);
		xfer(1, 0, 4'ha, 2'h1, 1'b1, 32'h0b22);
		xfer(2, 24'h001094, 4'h8, 2'h3, 1'b0, 0);
		xfer(3, 24'h00109c, 4'h8, 2'h3, 1'b0, 0);
		xfer(4, 24'h001094, 4'h8, 2'h3, 1'b0, 0);
		xfer(5, 0, 4'ha, 2'h1, 1'b1, 32'h0777);
		xfer(6, 0, 4'ha, 2'h3, 1'b1, 32'h400);
		check("pc descriptor", pcSeen, 32'h5a00109c + 32'h5a00);
		check("static base", staticBase, 32'h5a001094);
		check("new module", {16'h0, modSeen}, 32'h1094);
		// Cascaded source
		directException <= 1'b1;
		ackByte <= 8'hfe;
		casVec <= 8'h40;
		lag <= 4'h1;
		intReqN <= 1'b0;
		repeat (3) @(posedge clock);
		instrBoundary <= 1'b1;
		serve(6);
		xfer(1, 24'h000ff8, 4'h8, 2'h3, 1'b0, 0);
		xfer(2, 24'h000ff8, 4'h5, 2'h0, 1'b0, 0);
		xfer(4, 24'h001100, 4'h8, 2'h3, 1'b0, 0);
		// Every instruction trap
		lag <= 4'h0;
		for (int i = 0; i < 7; i++) begin
			trapReq <= 7'(1 << i);
			instrEnd <= 1'b1;
			serve(3);
			xfer(0, 0, 4'ha, 2'h1, 1'b1, (i == 6) ? 32'h0b26 : 32'h0f26);
			xfer(1, 24'h001000 + {14'h0, trapVec[i], 2'h0}, 4'h8, 2'h3, 1'b0, 0);
			xfer(2, 0, 4'ha, 2'h3, 1'b1, 32'h400);
			check("trap status", {16'h0, stSeen}, 32'h0824);
		end
		check("trap restores", restoreCnt, 7);
		// Trace trap left pending by the traced traps
		instrBoundary <= 1'b1;
		serve(3);
		xfer(0, 0, 4'ha, 2'h1, 1'b1, 32'h0b22);
		xfer(1, 24'h001024, 4'h8, 2'h3, 1'b0, 0);
		xfer(2, 0, 4'ha, 2'h3, 1'b1, 32'h406);
		check("trace status", {16'h0, stSeen}, 32'h0820);
		close_out();
	end
endmodule // exception_acknowledge_sequencer_tb_top
`default_nettype wire
